// File: hw/semr_regs.sv
// Error management register bank with AXI4-Lite slave
//
// How it works
// - Hard reset or self-reset returns all registers to reset values.
// - Port reset clears only that port's registers.
// - Boot loader may replace reset values of writable fields.
// - Powered-down port ignores writes and reads zero.
// - Bus and transport errors set bit 0 of port error detect.
// - Every register is 32 bits on an aligned word.
// - Header at base, eight port blocks at 64-byte spacing.
// - Policy chosen from stop and drop enables; drop acts at threshold, stop and flush on output failure.
// - Both clear: keep transmitting despite failure.
// - Drop only: discard not-accepted packets, set dropped bit.
// - Drop only: resume forwarding when counter below threshold.
// - Stop only: cease sending on failure, output congested.
// - Both set: discard without sending, set dropped bit.
// - Both set: discard only packets queued at failure.
// - Header upper half is hard-wired next pointer, zero.
// - Header lower half is feature id, header resets to constant.
// - Stop-on-failure enable is bit 28, read-write, reset zero.
// - Drop enable is bit 29, read-write, reset zero.
`timescale 1ns/10ps
module semr_regs import semr_pkg::*; #(
    parameter int PORTS = NUM_PORTS
) (
    // Clock and resets
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic selfReset,
    input wire logic [PORTS-1:0] portReset,
    // Boot loader
    input wire logic bootLoadValid,
    input wire logic [15:0] bootLoadAddr,
    input wire logic [31:0] bootLoadData,
    // Port status, pins from other domains
    input wire logic [PORTS-1:0] portPowerDown,
    input wire logic [PORTS-1:0] busAccessError,
    input wire logic [PORTS-1:0] transportError,
    input wire logic [PORTS*32-1:0] captureInfo,
    input wire logic [PORTS-1:0] thresholdMet,
    input wire logic [PORTS-1:0] outputFailed,
    input wire logic [PORTS*8-1:0] errorRateCounter,
    // Datapath events
    input wire logic [PORTS-1:0] pktQueued,
    input wire logic [PORTS-1:0] pktDequeued,
    input wire logic [PORTS-1:0] pktNotAccepted,
    // Policy outputs
    output logic [PORTS-1:0] txHold,
    output logic [PORTS-1:0] discardHead,
    output logic [PORTS-1:0] dropEvent,
    // AXI4-Lite write address
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Decode: port index, -1 style flags for header and misses
    function automatic logic [4:0] decodePort(input logic [15:0] a);
        logic [15:0] rel;
        rel = a - OFS_PORT_BASE;
        if (a < OFS_PORT_BASE || a >= OFS_PORT_LAST + OFS_PORT_STRIDE) begin
            decodePort = 5'h1F;
        end else begin
            decodePort = {1'b0, rel[9:6]};
        end
    endfunction : decodePort

    logic [PORTS-1:0] pwrDn;
    logic [PORTS-1:0] busErr;
    logic [PORTS-1:0] trErr;
    logic [PORTS-1:0] thrMet;
    logic [PORTS-1:0] outFail;
    semr_sync #(.W(PORTS)) syncPwr (.sys_clk(sys_clk), .rst_b(rst_b), .asyncIn(portPowerDown), .syncOut(pwrDn));
    semr_sync #(.W(PORTS)) syncBus (.sys_clk(sys_clk), .rst_b(rst_b), .asyncIn(busAccessError), .syncOut(busErr));
    semr_sync #(.W(PORTS)) syncTr (.sys_clk(sys_clk), .rst_b(rst_b), .asyncIn(transportError), .syncOut(trErr));
    semr_sync #(.W(PORTS)) syncThr (.sys_clk(sys_clk), .rst_b(rst_b), .asyncIn(thresholdMet), .syncOut(thrMet));
    semr_sync #(.W(PORTS)) syncFail (.sys_clk(sys_clk), .rst_b(rst_b), .asyncIn(outputFailed), .syncOut(outFail));

    // Write channel capture; address and data may arrive in either order
    logic awHave_r;
    logic wHave_r;
    logic [15:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic bValid_r;
    logic [1:0] bResp_r;
    logic rValid_r;
    logic [31:0] rData_r;
    logic [1:0] rResp_r;
    assign s_axi_awready = ~awHave_r & ~bValid_r;
    assign s_axi_wready = ~wHave_r & ~bValid_r;
    assign s_axi_arready = ~rValid_r;
    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp = bResp_r;
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata = rData_r;
    assign s_axi_rresp = rResp_r;

    wire writeFire = awHave_r & wHave_r & ~bValid_r;
    wire readFire = s_axi_arvalid & s_axi_arready;
    wire [4:0] wPort = decodePort(awAddr_r);
    wire [4:0] rPort = decodePort(s_axi_araddr);
    wire [5:0] wOfs = awAddr_r[5:0];
    wire [5:0] rOfs = s_axi_araddr[5:0];
    wire wHeader = awAddr_r == OFS_HEADER;
    wire rHeader = s_axi_araddr == OFS_HEADER;
    wire [31:0] wMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
    wire wMiss = ~wHeader & (wPort == 5'h1F || awAddr_r[1:0] != 2'h0);
    wire rMiss = ~rHeader & (rPort == 5'h1F || s_axi_araddr[1:0] != 2'h0);

    // Per-port register state
    logic [31:0] errDetect_r [PORTS];
    logic [31:0] errStatus_r [PORTS];
    logic [31:0] capture_r [PORTS];
    logic [31:0] rate_r [PORTS];
    logic [31:0] rdPort [PORTS];
    wire bankClear = selfReset;

    genvar gp;
    generate
        for (gp = 0; gp < PORTS; gp++) begin : gPort
            wire wSel = writeFire & ~wMiss & ~wHeader & (wPort == 5'(gp));
            wire wOk = wSel & ~pwrDn[gp];
            wire bootSel = bootLoadValid & (decodePort(bootLoadAddr) == 5'(gp));
            wire clr = bankClear | portReset[gp];
            // error flag into bit 0 (top bit, little-endian)
            wire errIn = busErr[gp] | trErr[gp];
            wire [31:0] wVal = wData_r & wMask;
            wire [31:0] sts = errStatus_r[gp];
            semr_port_policy uPol (
                .sys_clk(sys_clk), .rst_b(rst_b), .portClear(clr),
                .stopFailEn(sts[BIT_STOP_FAIL]), .dropEn(sts[BIT_DROP_EN]),
                .thresholdMet(thrMet[gp]), .outputFailed(outFail[gp]),
                .pktQueued(pktQueued[gp]), .pktDequeued(pktDequeued[gp]),
                .pktNotAccepted(pktNotAccepted[gp]),
                .txHold(txHold[gp]), .discardHead(discardHead[gp]),
                .dropEvent(dropEvent[gp]), .policy()
            );
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    errDetect_r[gp] <= 32'h00000000;
                    errStatus_r[gp] <= 32'h00000000;
                    capture_r[gp] <= 32'h00000000;
                    rate_r[gp] <= 32'h00000000;
                end else if (clr) begin
                    errDetect_r[gp] <= 32'h00000000;
                    errStatus_r[gp] <= 32'h00000000;
                    capture_r[gp] <= 32'h00000000;
                    rate_r[gp] <= 32'h00000000;
                end else if (bootSel) begin
                    if (bootLoadAddr[5:0] == PO_ERR_STATUS) errStatus_r[gp] <= bootLoadData & STATUS_RW_MASK;
                    if (bootLoadAddr[5:0] == PO_RATE) rate_r[gp] <= bootLoadData & RATE_RW_MASK;
                end else begin
                    // Set wins over software clear
                    if (errIn) begin
                        errDetect_r[gp][BIT_BUS_ERR] <= 1'b1;
                        capture_r[gp] <= captureInfo[gp*32 +: 32];
                    end else if (wOk && wOfs == PO_ERR_DETECT) begin
                        errDetect_r[gp] <= errDetect_r[gp] & ~(wMask & ~wData_r);
                    end
                    if (wOk && wOfs == PO_ERR_STATUS) begin
                        errStatus_r[gp][BIT_STOP_FAIL] <= wMask[BIT_STOP_FAIL] ? wVal[BIT_STOP_FAIL] : sts[BIT_STOP_FAIL];
                        errStatus_r[gp][BIT_DROP_EN] <= wMask[BIT_DROP_EN] ? wVal[BIT_DROP_EN] : sts[BIT_DROP_EN];
                    end
                    if (dropEvent[gp]) begin
                        errStatus_r[gp][BIT_PKT_DROPPED] <= 1'b1;
                    end else if (wOk && wOfs == PO_ERR_STATUS && wVal[BIT_PKT_DROPPED]) begin
                        errStatus_r[gp][BIT_PKT_DROPPED] <= 1'b0;
                    end
                    errStatus_r[gp][BIT_OUT_FAILED] <= outFail[gp];
                    if (wOk && wOfs == PO_RATE) begin
                        rate_r[gp] <= ((rate_r[gp] & ~wMask) | wVal) & RATE_RW_MASK;
                    end
                end
            end
            assign rdPort[gp] = pwrDn[gp] ? 32'h00000000 :
                (rOfs == PO_ERR_DETECT) ? errDetect_r[gp] :
                (rOfs == PO_ERR_STATUS) ? errStatus_r[gp] :
                (rOfs == PO_CAPTURE) ? capture_r[gp] :
                (rOfs == PO_RATE) ? {rate_r[gp][31:16], errorRateCounter[gp*8 +: 8], rate_r[gp][7:0]} :
                32'h00000000;
        end
    endgenerate

    wire [31:0] headerWord = {NEXT_BLOCK_POINTER, FEATURE_BLOCK_ID};
    wire [31:0] rdSel = rHeader ? headerWord : rMiss ? 32'h00000000 : rdPort[rPort[2:0]];

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            awAddr_r <= 16'h0000;
            wData_r <= 32'h00000000;
            wStrb_r <= 4'h0;
            bValid_r <= 1'b0;
            bResp_r <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            // header write answered OKAY, no effect
            if (writeFire) begin
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
                bValid_r <= 1'b1;
                bResp_r <= wMiss ? RESP_SLVERR : RESP_OKAY;
            end else if (bValid_r && s_axi_bready) begin
                bValid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rValid_r <= 1'b0;
            rData_r <= 32'h00000000;
            rResp_r <= RESP_OKAY;
        end else if (readFire) begin
            rValid_r <= 1'b1;
            rData_r <= rdSel;
            rResp_r <= rMiss ? RESP_SLVERR : RESP_OKAY;
        end else if (rValid_r && s_axi_rready) begin
            rValid_r <= 1'b0;
        end
    end
endmodule : semr_regs

// File: hw/semr_pkg.sv
// Shared constants for the error management register bank
package semr_pkg;
    localparam int NUM_PORTS = 8;
    localparam logic [15:0] OFS_HEADER = 16'h1000;
    localparam logic [15:0] OFS_PORT_BASE = 16'h1040;
    localparam logic [15:0] OFS_PORT_STRIDE = 16'h0040;
    localparam logic [15:0] OFS_PORT_LAST = 16'h1200;
    // Per-port word offsets within a 64-byte port block
    localparam logic [5:0] PO_ERR_DETECT = 6'h00;
    localparam logic [5:0] PO_ERR_STATUS = 6'h04;
    localparam logic [5:0] PO_CAPTURE = 6'h08;
    localparam logic [5:0] PO_RATE = 6'h0C;
    localparam logic [15:0] NEXT_BLOCK_POINTER = 16'h0000;
    localparam logic [15:0] FEATURE_BLOCK_ID = 16'h0007;
    localparam logic [31:0] HEADER_RESET = 32'h00000007;
    // Bit positions, little-endian numbering (big-endian bit 28 -> 3, etc.)
    localparam int BIT_STOP_FAIL = 3;
    localparam int BIT_DROP_EN = 2;
    localparam int BIT_PKT_DROPPED = 4;
    localparam int BIT_OUT_FAILED = 5;
    localparam int BIT_BUS_ERR = 31;
    localparam logic [31:0] STATUS_RW_MASK = 32'h0000000C;
    localparam logic [31:0] STATUS_W1C_MASK = 32'h00000010;
    localparam logic [31:0] RATE_RW_MASK = 32'hFFFF00FF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {SEMR_CONTINUE, SEMR_DROP, SEMR_STOP, SEMR_FLUSH} semr_policy_type;
endpackage : semr_pkg

// File: hw/semr_sync.sv
// Three-stage synchroniser with second/third agreement
`timescale 1ns/10ps
module semr_sync #(parameter int W = 1) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Data
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] out_r;
    logic [W-1:0] out_nxt;
    assign out_nxt = (s2_r & s3_r) | (out_r & (s2_r | s3_r));
    assign syncOut = out_r;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end else begin
            s1_r <= asyncIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end
endmodule : semr_sync

// File: hw/semr_port_policy.sv
// Per-port output policy: drop once the failed threshold is met, stop and flush on output failure
`timescale 1ns/10ps
module semr_port_policy import semr_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic portClear,
    // Control
    input wire logic stopFailEn,
    input wire logic dropEn,
    input wire logic thresholdMet,
    input wire logic outputFailed,
    // Datapath events
    input wire logic pktQueued,
    input wire logic pktDequeued,
    input wire logic pktNotAccepted,
    // Results
    output logic txHold,
    output logic discardHead,
    output logic dropEvent,
    output semr_policy_type policy
);
    logic [15:0] flushCount_r;
    logic [15:0] flushCount_nxt;
    logic [15:0] depth_r;
    logic [15:0] depth_nxt;
    logic failRise;
    logic outputFailed_r;
    assign policy = semr_policy_type'({stopFailEn, dropEn});
    assign failRise = outputFailed & ~outputFailed_r;
    assign txHold = (policy == SEMR_STOP) && outputFailed;
    // flush only packets stored at failure
    assign discardHead = (policy == SEMR_FLUSH) && outputFailed && (flushCount_r != 16'h0000);
    assign dropEvent = ((policy == SEMR_DROP) && thresholdMet && pktNotAccepted) ||
                       (discardHead && pktDequeued);
    assign depth_nxt = depth_r + {15'h0000, pktQueued} - {15'h0000, pktDequeued};
    assign flushCount_nxt = failRise ? depth_r :
                            (discardHead && pktDequeued) ? flushCount_r - 16'h0001 : flushCount_r;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            depth_r <= 16'h0000;
            flushCount_r <= 16'h0000;
            outputFailed_r <= 1'b0;
        end else if (portClear) begin
            depth_r <= 16'h0000;
            flushCount_r <= 16'h0000;
            outputFailed_r <= 1'b0;
        end else begin
            depth_r <= depth_nxt;
            flushCount_r <= flushCount_nxt;
            outputFailed_r <= outputFailed;
        end
    end
endmodule : semr_port_policy

// File: bench/semr_regs_assertions.sv
// Concurrent checks on the register bank ports
`timescale 1ns/10ps
module semr_regs_checker import semr_pkg::*; #(
    parameter int PORTS = NUM_PORTS
) (
    // Clock and resets
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic selfReset,
    input wire logic [PORTS-1:0] portReset,
    // Policy
    input wire logic [PORTS-1:0] pktNotAccepted,
    input wire logic [PORTS-1:0] txHold,
    input wire logic [PORTS-1:0] discardHead,
    input wire logic [PORTS-1:0] dropEvent,
    // Bus
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire arTaken = s_axi_arvalid && s_axi_arready;
    wire hdrRead = arTaken && s_axi_araddr == OFS_HEADER;
    hdr_ptr_a: assert property (hdrRead |=> s_axi_rvalid && s_axi_rdata[31:16] == NEXT_BLOCK_POINTER)
        else $error("header pointer half wrong");
    hdr_id_a: assert property (hdrRead |=> s_axi_rdata[15:0] == FEATURE_BLOCK_ID)
        else $error("header id half wrong");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read word changed while stalled");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped while stalled");
    misalign_err_a: assert property (arTaken && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == RESP_SLVERR)
        else $error("unaligned read not refused");
    policy_excl_a: assert property (!(|(txHold & discardHead)))
        else $error("stop and flush at once");
    drop_cause_a: assert property (!(|(dropEvent & ~(pktNotAccepted | discardHead))))
        else $error("discard without cause");
    self_clear_a: assert property (selfReset [*2] |-> txHold == '0 && discardHead == '0)
        else $error("policy survives self reset");
    port_clear_a: assert property (!(|(portReset & $past(portReset) & (txHold | discardHead))))
        else $error("policy survives port reset");
    hdr_c: cover property (hdrRead);
    drop_c: cover property (|dropEvent);
    flush_c: cover property ($rose(|discardHead));
endmodule : semr_regs_checker

bind semr_regs semr_regs_checker #(.PORTS(PORTS)) chk (.*);

// File: bench/semr_pe_model.sv
// Processing element model: register bus master
`timescale 1ns/10ps
module semr_pe_model (
    // Clock
    input wire logic sys_clk,
    // Write channels
    output logic [15:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // Read channels
    output logic [15:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [15:0] a, input logic [31:0] v, output logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge sys_clk);
            // Released lines show the inverse, never a stale value
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~v;
            end
        end
        do @(posedge sys_clk); while (!s_axi_bvalid);
        // Late ready stalls the answer one cycle so its hold is exercised
        s_axi_bready <= 1'b1;
        @(posedge sys_clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge sys_clk);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : semr_pe_model

// File: bench/semr_regs_bench.sv
// Self-checking bench for the error management register bank
`timescale 1ns/10ps
module semr_regs_bench import semr_pkg::*;;
    logic sys_clk, rst_b, selfReset, bootLoadValid;
    logic [7:0] portReset, portPowerDown, busAccessError, transportError, thresholdMet, outputFailed;
    logic [7:0] pktQueued, pktDequeued, pktNotAccepted, txHold, discardHead, dropEvent;
    logic [15:0] bootLoadAddr, s_axi_awaddr, s_axi_araddr;
    logic [31:0] bootLoadData, s_axi_wdata, s_axi_rdata;
    logic [255:0] captureInfo;
    logic [63:0] errorRateCounter;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int failures, comparisons;

    semr_regs #(.PORTS(8)) dut (.*);
    semr_pe_model pe (.*);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic wrap_up;
        if (failures == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [15:0] pa(input int n, input logic [5:0] o);
        return OFS_PORT_BASE + OFS_PORT_STRIDE * n[15:0] + {10'h0, o};
    endfunction : pa

    task automatic rdck(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] v;
        logic [1:0] r;
        pe.rd(a, v, r);
        chk(v, e);
        chk({30'h0, r}, {30'h0, er});
    endtask : rdck

    task automatic wrck(input logic [15:0] a, input logic [31:0] v, input logic [1:0] er);
        logic [1:0] r;
        pe.wr(a, v, r);
        chk({30'h0, r}, {30'h0, er});
    endtask : wrck

    // Settled outputs are looked at on the falling edge
    task automatic waitc(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : waitc

    // Kind 0 refused, 1 dequeued, else queued; one-cycle pulse
    task automatic pkt(input int kind, input int p, input logic e);
        @(posedge sys_clk);
        case (kind)
            0: pktNotAccepted[p] <= 1'b1;
            1: pktDequeued[p] <= 1'b1;
            default: pktQueued[p] <= 1'b1;
        endcase
        @(negedge sys_clk);
        chk({31'h0, dropEvent[p]}, {31'h0, e});
        @(posedge sys_clk);
        {pktNotAccepted, pktDequeued, pktQueued} <= '0;
    endtask : pkt

    initial begin
        {rst_b, selfReset, bootLoadValid, bootLoadAddr, bootLoadData, portReset, portPowerDown} = '0;
        {busAccessError, transportError, thresholdMet, outputFailed, errorRateCounter} = '0;
        {pktQueued, pktDequeued, pktNotAccepted, failures, comparisons} = '0;
        captureInfo = {32'h0, 32'hA5A50F0F, 192'h0};
        errorRateCounter = {8'h5A, 56'h0};
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        rdck(OFS_HEADER, HEADER_RESET, RESP_OKAY);
        wrck(OFS_HEADER, 32'hFFFFFFFF, RESP_OKAY);
        rdck(OFS_HEADER, HEADER_RESET, RESP_OKAY);
        rdck(16'h1004, 32'h0, RESP_SLVERR);
        rdck(16'h1042, 32'h0, RESP_SLVERR);
        for (int n = 0; n < 8; n++) begin
            rdck(pa(n, PO_ERR_STATUS), 32'h0, RESP_OKAY);
            wrck(pa(n, PO_ERR_STATUS), STATUS_RW_MASK, RESP_OKAY);
            rdck(pa(n, PO_ERR_STATUS), STATUS_RW_MASK, RESP_OKAY);
        end
        wrck(pa(0, PO_ERR_STATUS), 32'h4, RESP_OKAY);
        thresholdMet[0] <= 1'b1;
        wrck(pa(2, PO_ERR_STATUS), 32'h0, RESP_OKAY);
        {outputFailed[2], thresholdMet[2], outputFailed[1]} <= 3'h7;
        wrck(pa(1, PO_ERR_STATUS), 32'h8, RESP_OKAY);
        waitc(6);
        chk({31'h0, txHold[2]}, 32'h0);
        chk({31'h0, txHold[1]}, 32'h1);
        pkt(0, 2, 1'b0);
        pkt(0, 0, 1'b1);
        rdck(pa(0, PO_ERR_STATUS), 32'h14, RESP_OKAY);
        wrck(pa(0, PO_ERR_STATUS), 32'h14, RESP_OKAY);
        rdck(pa(0, PO_ERR_STATUS), 32'h4, RESP_OKAY);
        rdck(pa(2, PO_ERR_STATUS), 32'h20, RESP_OKAY);
        thresholdMet[0] <= 1'b0;
        waitc(6);
        pkt(0, 0, 1'b0);
        pkt(2, 3, 1'b0);
        pkt(2, 3, 1'b0);
        outputFailed[3] <= 1'b1;
        waitc(6);
        chk({31'h0, discardHead[3]}, 32'h1);
        pkt(2, 3, 1'b0);
        pkt(1, 3, 1'b1);
        pkt(1, 3, 1'b1);
        waitc(1);
        chk({31'h0, discardHead[3]}, 32'h0);
        pkt(1, 3, 1'b0);
        rdck(pa(3, PO_ERR_STATUS), 32'h3C, RESP_OKAY);
        portPowerDown[4] <= 1'b1;
        waitc(6);
        rdck(pa(4, PO_ERR_STATUS), 32'h0, RESP_OKAY);
        wrck(pa(4, PO_ERR_STATUS), 32'h0, RESP_OKAY);
        portPowerDown[4] <= 1'b0;
        waitc(6);
        rdck(pa(4, PO_ERR_STATUS), STATUS_RW_MASK, RESP_OKAY);
        portReset[5] <= 1'b1;
        busAccessError[6] <= 1'b1;
        transportError[7] <= 1'b1;
        waitc(6);
        @(posedge sys_clk);
        {portReset, busAccessError, transportError} <= '0;
        rdck(pa(5, PO_ERR_STATUS), 32'h0, RESP_OKAY);
        rdck(pa(6, PO_ERR_STATUS), STATUS_RW_MASK, RESP_OKAY);
        rdck(pa(6, PO_ERR_DETECT), 32'h80000000, RESP_OKAY);
        rdck(pa(6, PO_CAPTURE), 32'hA5A50F0F, RESP_OKAY);
        rdck(pa(7, PO_ERR_DETECT), 32'h80000000, RESP_OKAY);
        wrck(pa(7, PO_ERR_DETECT), 32'h7FFFFFFF, RESP_OKAY);
        rdck(pa(7, PO_ERR_DETECT), 32'h0, RESP_OKAY);
        @(posedge sys_clk);
        selfReset <= 1'b1;
        waitc(3);
        @(posedge sys_clk);
        selfReset <= 1'b0;
        rdck(pa(6, PO_ERR_STATUS), 32'h0, RESP_OKAY);
        rdck(pa(6, PO_ERR_DETECT), 32'h0, RESP_OKAY);
        @(posedge sys_clk);
        {bootLoadValid, bootLoadAddr, bootLoadData} <= {1'b1, pa(7, PO_ERR_STATUS), 32'h8};
        @(posedge sys_clk);
        bootLoadValid <= 1'b0;
        rdck(pa(7, PO_ERR_STATUS), 32'h8, RESP_OKAY);
        wrck(pa(7, PO_RATE), 32'hFFFFFFFF, RESP_OKAY);
        rdck(pa(7, PO_RATE), 32'hFFFF5AFF, RESP_OKAY);
        wrap_up();
    end

    initial begin
        #800000;
        failures++;
        wrap_up();
    end
endmodule : semr_regs_bench
